// ==== common/hbpd_pkg.sv ====
// Purpose: shared constants for the H-bridge parallel drive pair
// Assumes: 40 MHz system clock
// Notes: host registers sit on AHB-Lite, one word each
`default_nettype none
package hbpd_pkg;
   // ==========================================
   // Timing
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned PWM_MAX_HZ = 20000;
   localparam int unsigned PWM_MIN_PERIOD = (CLK_HZ + PWM_MAX_HZ - 1) / PWM_MAX_HZ;
   localparam int unsigned DUTY_MIN_PCT = 10;
   localparam int unsigned DUTY_MAX_PCT = 90;
   localparam int unsigned PCT_FULL = 100;
   localparam int unsigned CNT_W = 16;
   // ==========================================
   // Host register offsets
   localparam logic [7:0] REG_CTRL_OFS = 8'h00;
   localparam logic [7:0] REG_PERIOD_OFS = 8'h04;
   localparam logic [7:0] REG_HIGH_OFS = 8'h08;
   localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
   // ==========================================
   // Control fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_DIR_BIT = 2;
   localparam int CTRL_RECIRC_BIT = 3;
   localparam int CTRL_HALF_BIT = 4;
   localparam int CTRL_WAKE_BIT = 5;
   localparam int CTRL_TRI_BIT = 6;
   localparam logic [CNT_W-1:0] PERIOD_RST = 16'h07D0;
   localparam logic [CNT_W-1:0] HIGH_RST = 16'h03E8;
   // ==========================================
   // Status fields
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_BADCFG_BIT = 1;
   localparam int STAT_BADPWM_BIT = 2;
   // ==========================================
   // Bridge leg drive states
   typedef enum logic [1:0] {
      HBPD_LEG_HIZ,
      HBPD_LEG_HIGH,
      HBPD_LEG_LOW
   } hbpd_leg_t;
endpackage
`default_nettype wire

// ==== common/hbpd_if.sv ====
// Purpose: parallel pins between host and bridge
// Assumes: both ends on one clock
// Notes: plain levels only
`timescale 1ns/10ps
`default_nettype none
interface hbpd_if;
   logic driver_wake_enable;
   logic output_tristate_ctrl;
   logic bridge_input_a;
   logic bridge_input_b;
   modport host (
      output driver_wake_enable,
      output output_tristate_ctrl,
      output bridge_input_a,
      output bridge_input_b
   );
   modport device (
      input driver_wake_enable,
      input output_tristate_ctrl,
      input bridge_input_a,
      input bridge_input_b
   );
endinterface
`default_nettype wire

// ==== hdl/hbpd_bridge.sv ====
// Purpose: bridge side, maps parallel inputs to output legs
// Assumes: pins arrive asynchronous, two-flop synchronised
// Notes: leg outputs carry drive, level and enable
`timescale 1ns/10ps
`default_nettype none
module hbpd_bridge
   import hbpd_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Parallel pins
   hbpd_if.device pins,
   // Bridge outputs
   output logic bridge_output_a_o,
   output logic bridge_output_a_oe_o,
   output logic bridge_output_b_o,
   output logic bridge_output_b_oe_o,
   output logic sleep_o
);
   logic [1:0] wake_sy, tri_sy, ina_sy, inb_sy;

   // ==========================================
   // Input synchronisers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wake_sy <= 2'h0;
         tri_sy <= 2'h3;
         ina_sy <= 2'h0;
         inb_sy <= 2'h0;
      end else begin
         wake_sy <= {wake_sy[0], pins.driver_wake_enable};
         tri_sy <= {tri_sy[0], pins.output_tristate_ctrl};
         ina_sy <= {ina_sy[0], pins.bridge_input_a};
         inb_sy <= {inb_sy[0], pins.bridge_input_b};
      end
   end

   // ==========================================
   // Output legs
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         bridge_output_a_o <= 1'h0;
         bridge_output_b_o <= 1'h0;
         bridge_output_a_oe_o <= 1'h0;
         bridge_output_b_oe_o <= 1'h0;
         sleep_o <= 1'h1;
      end else begin
         sleep_o <= !wake_sy[1];
         bridge_output_a_oe_o <= wake_sy[1] && !tri_sy[1];
         bridge_output_b_oe_o <= wake_sy[1] && !tri_sy[1];
         bridge_output_a_o <= ina_sy[1];
         bridge_output_b_o <= inb_sy[1];
      end
   end
endmodule
`default_nettype wire

// ==== hdl/hbpd_host.sv ====
// Purpose: host PWM generator with AHB-Lite control registers
// Assumes: single word transfers, OKAY only
// Notes: period and high time latched at period end
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module hbpd_host
   import hbpd_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Parallel pins
   hbpd_if.host pins
);
   logic wr_pend_reg, rd_now;
   logic [7:0] wr_addr_reg;
   logic dir_reg, recirc_low_reg, half_reg, wake_reg, tri_reg, run_reg;
   logic [CNT_W-1:0] period_reg, high_reg, act_period_reg, act_high_reg, cnt_reg;
   logic pwm_reg, cfg_ok, pwm_ok;
   logic [CNT_W+7:0] high_pct, per_min, per_max;

   // ==========================================
   // Bus slave
   assign rd_now = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wr_pend_reg <= 1'h0;
         wr_addr_reg <= 8'h00;
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'h1;
         hresp_o <= 1'h0;
      end else begin
         hreadyout_o <= 1'h1;
         hresp_o <= 1'h0;
         if (hready_i) begin
            wr_pend_reg <= hsel_i && htrans_i[1] && hwrite_i;
            wr_addr_reg <= haddr_i;
         end
         if (rd_now) begin
            case (haddr_i)
               REG_CTRL_OFS: begin
                  hrdata_o <= 32'h0000_0000;
                  hrdata_o[CTRL_DIR_BIT] <= dir_reg;
                  hrdata_o[CTRL_RECIRC_BIT] <= recirc_low_reg;
                  hrdata_o[CTRL_HALF_BIT] <= half_reg;
                  hrdata_o[CTRL_WAKE_BIT] <= wake_reg;
                  hrdata_o[CTRL_TRI_BIT] <= tri_reg;
               end
               REG_PERIOD_OFS: hrdata_o <= 32'(period_reg);
               REG_HIGH_OFS: hrdata_o <= 32'(high_reg);
               REG_STATUS_OFS: begin
                  hrdata_o <= 32'h0000_0000;
                  hrdata_o[STAT_RUN_BIT] <= run_reg;
                  hrdata_o[STAT_BADCFG_BIT] <= !cfg_ok;
                  hrdata_o[STAT_BADPWM_BIT] <= !pwm_ok;
               end
               default: hrdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================
   // Control registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         dir_reg <= 1'h0;
         recirc_low_reg <= 1'h0;
         half_reg <= 1'h0;
         wake_reg <= 1'h0;
         tri_reg <= 1'h1;
         period_reg <= PERIOD_RST;
         high_reg <= HIGH_RST;
      end else if (wr_pend_reg) begin
         case (wr_addr_reg)
            REG_CTRL_OFS: begin
               dir_reg <= hwdata_i[CTRL_DIR_BIT];
               recirc_low_reg <= hwdata_i[CTRL_RECIRC_BIT];
               half_reg <= hwdata_i[CTRL_HALF_BIT];
               wake_reg <= hwdata_i[CTRL_WAKE_BIT];
               tri_reg <= hwdata_i[CTRL_TRI_BIT];
            end
            REG_PERIOD_OFS: period_reg <= hwdata_i[CNT_W-1:0];
            REG_HIGH_OFS: high_reg <= hwdata_i[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // Setting checks
   // low-side refused in H-bridge
   assign cfg_ok = half_reg || !recirc_low_reg;
   assign high_pct = (CNT_W+8)'(high_reg) * (CNT_W+8)'(PCT_FULL);
   assign per_min = (CNT_W+8)'(period_reg) * (CNT_W+8)'(DUTY_MIN_PCT);
   assign per_max = (CNT_W+8)'(period_reg) * (CNT_W+8)'(DUTY_MAX_PCT);
   assign pwm_ok = (period_reg >= CNT_W'(PWM_MIN_PERIOD)) && (high_pct >= per_min)
                   && (high_pct <= per_max);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         run_reg <= 1'h0;
      end else if (wr_pend_reg && wr_addr_reg == REG_CTRL_OFS) begin
         if (hwdata_i[CTRL_STOP_BIT]) begin
            run_reg <= 1'h0;
         end else if (hwdata_i[CTRL_START_BIT] && cfg_ok && pwm_ok) begin
            run_reg <= 1'h1;
         end
      end
   end

   // ==========================================
   // PWM counter
   // reload at period boundary
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
         act_period_reg <= PERIOD_RST;
         act_high_reg <= HIGH_RST;
         pwm_reg <= 1'h0;
      end else if (!run_reg) begin
         cnt_reg <= '0;
         act_period_reg <= period_reg;
         act_high_reg <= high_reg;
         pwm_reg <= 1'h0;
      end else begin
         if (cnt_reg >= act_period_reg - CNT_W'(1)) begin
            cnt_reg <= '0;
            if (pwm_ok) begin
               act_period_reg <= period_reg;
               act_high_reg <= high_reg;
            end
            pwm_reg <= 1'h1;
         end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
            pwm_reg <= (cnt_reg + CNT_W'(1)) < act_high_reg;
         end
      end
   end

   // ==========================================
   // Pin drive
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pins.driver_wake_enable <= 1'h0;
         pins.output_tristate_ctrl <= 1'h1;
         pins.bridge_input_a <= 1'h0;
         pins.bridge_input_b <= 1'h0;
      end else begin
         pins.driver_wake_enable <= wake_reg;
         pins.output_tristate_ctrl <= tri_reg;
         if (!run_reg || !cfg_ok) begin
            pins.bridge_input_a <= 1'h0;
            pins.bridge_input_b <= 1'h0;
         end else if (!recirc_low_reg && !dir_reg) begin
            pins.bridge_input_a <= 1'h1;
            pins.bridge_input_b <= pwm_reg;
         end else if (!recirc_low_reg && half_reg) begin
            pins.bridge_input_a <= pwm_reg;
            pins.bridge_input_b <= 1'h1;
         end else if (!recirc_low_reg) begin
            pins.bridge_input_a <= 1'h0;
            pins.bridge_input_b <= pwm_reg;
         end else if (!dir_reg) begin
            pins.bridge_input_a <= pwm_reg;
            pins.bridge_input_b <= 1'h0;
         end else begin
            pins.bridge_input_a <= 1'h0;
            pins.bridge_input_b <= pwm_reg;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/hbpd_asserts.sv ====
// Purpose: pin-level checks across host and bridge
// Assumes: legs follow pins three edges later
// Notes: watches the interface and bridge outputs
`timescale 1ns/10ps
`default_nettype none
module hbpd_asserts (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Pins and legs
   input wire logic driver_wake_enable_i,
   input wire logic output_tristate_ctrl_i,
   input wire logic bridge_input_a_i,
   input wire logic bridge_input_b_i,
   input wire logic bridge_output_a_i,
   input wire logic bridge_output_a_oe_i,
   input wire logic bridge_output_b_i,
   input wire logic bridge_output_b_oe_i,
   input wire logic sleep_i
);
   logic [1:0] settle_reg;
   logic settled;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Edges since reset release
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         settle_reg <= 2'h0;
      end else if (settle_reg != 2'h3) begin
         settle_reg <= settle_reg + 2'h1;
      end
   end
   assign settled = (settle_reg == 2'h3);
   sequence wake_up_s;
      $rose(driver_wake_enable_i);
   endsequence
   sequence tri_off_s;
      $fell(output_tristate_ctrl_i) && driver_wake_enable_i;
   endsequence
   // ==========================================
   // Checks
   wake_follow_a: assert property (settled && $past(driver_wake_enable_i, 3)
      && !$past(output_tristate_ctrl_i, 3) |-> bridge_output_a_i == $past(bridge_input_a_i, 3)
      && bridge_output_b_i == $past(bridge_input_b_i, 3)) else $error("legs do not follow");
   sleep_follow_a: assert property (settled |-> sleep_i == !$past(driver_wake_enable_i, 3))
      else $error("sleep does not track wake");
   asleep_float_a: assert property (sleep_i |-> !bridge_output_a_oe_i
      && !bridge_output_b_oe_i) else $error("leg driven while asleep");
   wake_step_a: assert property (wake_up_s |-> ##2 sleep_i ##1 !sleep_i)
      else $error("wake took wrong time");
   tri_float_a: assert property (settled && $past(output_tristate_ctrl_i, 3)
      |-> !bridge_output_a_oe_i && !bridge_output_b_oe_i) else $error("leg driven in tristate");
   enable_both_a: assert property (settled && $past(driver_wake_enable_i, 3)
      && !$past(output_tristate_ctrl_i, 3) |-> bridge_output_a_oe_i && bridge_output_b_oe_i)
      else $error("legs not enabled");
   tri_release_a: assert property (tri_off_s |-> ##3 bridge_output_a_oe_i
      && bridge_output_b_oe_i) else $error("tristate release late");
   legs_paired_a: assert property (bridge_output_a_oe_i == bridge_output_b_oe_i)
      else $error("leg enables differ");
endmodule
`default_nettype wire

// ==== test/hbpd_tb_top.sv ====
// Purpose: drives host registers, watches bridge legs
// Assumes: hreadyout feeds back as hready
// Notes: PWM period 2000 clocks in every run
`timescale 1ns/10ps
`default_nettype none
module hbridge_parallel_drive_tb_top
   import hbpd_pkg::*;
;
   logic clk, rst_n, hwrite, mon_sel;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, rd;
   wire logic [31:0] hrdata;
   wire logic hready, hresp, boa, aoe, bob, boe, slp;
   wire logic pwm_w = mon_sel ? bob : boa;
   wire logic cst_w = mon_sel ? boa : bob;
   int miscompares = 0;
   int num_checks = 0;
   int mon_idx;
   logic [5:0] mctl [6] = '{6'h20, 6'h30, 6'h34, 6'h24, 6'h38, 6'h3C};
   logic [5:0] monb = 6'h2B;
   logic [5:0] cval = 6'h07;
   logic [31:0] bad [4][4] = '{'{32'h7D0, 32'h3E8, 32'h28, 32'h2}, '{32'h7CF, 32'h3E7, 32'h20,
      32'h4}, '{32'h7D0, 32'hC7, 32'h20, 32'h4}, '{32'h7D0, 32'h709, 32'h20, 32'h4}};
   hbpd_if u_hbpd_if ();
   hbpd_host u_hbpd_host (.clock_i(clk), .rst_n_i(rst_n), .hsel_i(1'h1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .pins(u_hbpd_if));
   hbpd_bridge u_hbpd_bridge (.clock_i(clk), .rst_n_i(rst_n), .pins(u_hbpd_if),
      .bridge_output_a_o(boa), .bridge_output_a_oe_o(aoe), .bridge_output_b_o(bob),
      .bridge_output_b_oe_o(boe), .sleep_o(slp));
   hbpd_asserts u_hbpd_asserts (.clock_i(clk), .rst_n_i(rst_n),
      .driver_wake_enable_i(u_hbpd_if.driver_wake_enable),
      .output_tristate_ctrl_i(u_hbpd_if.output_tristate_ctrl),
      .bridge_input_a_i(u_hbpd_if.bridge_input_a),
      .bridge_input_b_i(u_hbpd_if.bridge_input_b),
      .bridge_output_a_i(boa), .bridge_output_a_oe_i(aoe), .bridge_output_b_i(bob),
      .bridge_output_b_oe_i(boe), .sleep_i(slp));
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   // ==========================================
   // Tasks
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'h1) begin
         n++;
         if (n > 50) begin
            check_word(32'h0, 32'h1);
            tally_and_finish;
         end
         @(posedge clk);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hwrite <= w;
      haddr <= a;
      htrans <= 2'h2;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
      rd = hrdata;
      check_word({31'h0, hresp}, 32'h0);
   endtask
   task automatic pins_after(input logic [3:0] exp);
      repeat (6) @(negedge clk);
      check_word({28'h0, slp, aoe, boe, boa | bob}, {28'h0, exp});
   endtask
   task automatic measure(input logic [31:0] hi);
      int n;
      int h;
      int bad_n;
      h = 0;
      bad_n = 0;
      @(negedge clk);
      for (n = 0; n < 5000 && pwm_w !== 1'h0; n++) @(negedge clk);
      for (n = n; n < 9000 && pwm_w !== 1'h1; n++) @(negedge clk);
      if (n >= 9000) begin
         check_word(32'h0, 32'h1);
         tally_and_finish;
      end
      for (n = 0; n < 2000; n++) begin
         h += (pwm_w === 1'h1);
         bad_n += (cst_w !== cval[5 - mon_idx]);
         @(negedge clk);
      end
      check_word(32'(h), hi);
      check_word(32'(bad_n), 32'h0);
   endtask
   // ==========================================
   // Sequence
   initial begin
      rst_n = 1'h0;
      hwrite = 1'h0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwdata = 32'h0;
      mon_sel = 1'h0;
      mon_idx = 5;
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      bus(1'h0, REG_PERIOD_OFS, 32'h0);
      check_word(rd, {16'h0, PERIOD_RST});
      bus(1'h0, REG_HIGH_OFS, 32'h0);
      check_word(rd, {16'h0, HIGH_RST});
      bus(1'h0, 8'h10, 32'h0);
      check_word(rd, 32'h0);
      pins_after(4'h8);
      bus(1'h1, REG_CTRL_OFS, 32'h20);
      pins_after(4'h6);
      bus(1'h1, REG_CTRL_OFS, 32'h60);
      pins_after(4'h0);
      bus(1'h1, REG_CTRL_OFS, 32'h40);
      pins_after(4'h8);
      for (int i = 0; i < 4; i++) begin
         bus(1'h1, REG_PERIOD_OFS, bad[i][0]);
         bus(1'h1, REG_HIGH_OFS, bad[i][1]);
         bus(1'h1, REG_CTRL_OFS, bad[i][2]);
         bus(1'h1, REG_CTRL_OFS, bad[i][2] | 32'h1);
         bus(1'h0, REG_STATUS_OFS, 32'h0);
         check_word(rd & (32'h1 | bad[i][3]), bad[i][3]);
      end
      bus(1'h1, REG_PERIOD_OFS, 32'h7D0);
      for (int i = 0; i < 6; i++) begin
         mon_sel = monb[i];
         mon_idx = 5 - i;
         bus(1'h1, REG_HIGH_OFS, (i % 2) ? 32'h708 : 32'hC8);
         bus(1'h1, REG_CTRL_OFS, {26'h0, mctl[i]});
         bus(1'h1, REG_CTRL_OFS, {26'h0, mctl[i]} | 32'h1);
         bus(1'h0, REG_STATUS_OFS, 32'h0);
         check_word(rd & 32'h1, 32'h1);
         measure((i % 2) ? 32'h708 : 32'hC8);
         if (i == 5) begin
            bus(1'h1, REG_HIGH_OFS, 32'h3E8);
            measure(32'h3E8);
         end
         bus(1'h1, REG_CTRL_OFS, {26'h0, mctl[i]} | 32'h2);
         pins_after(4'h6);
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
